// ==== rtl/brgen_consts.vh ====
`ifndef BRGEN_CONSTS_VH
`define BRGEN_CONSTS_VH
// byte addresses of the register words
`define BRGEN_OFS_DIV_LOW 4'h0
`define BRGEN_OFS_DIV_HIGH 4'h4
`define BRGEN_OFS_CTRL 4'h8
`define BRGEN_OFS_STATUS 4'hc
// control word fields
`define BRGEN_CTRL_WIDE 0
`define BRGEN_CTRL_HIGH_SPEED 1
`define BRGEN_CTRL_SYNC 2
// status word fields
`define BRGEN_STAT_RUN_WIDE 0
`define BRGEN_STAT_MULT_LSB 1
// reset values
`define BRGEN_DIV_RESET 8'h00
`define BRGEN_CTRL_RESET 3'h0
`define BRGEN_RDATA_RESET 32'h00000000
`define BRGEN_COUNT_RESET 16'h0000
// period multipliers in clock cycles
`define BRGEN_MULT_64 7'h40
`define BRGEN_MULT_16 7'h10
`define BRGEN_MULT_4 7'h04
`define BRGEN_MULT_1 7'h01
`endif

// ==== rtl/brgen_prescaler.v ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// period multiplier prescaler
// ****************************************
module brgen_prescaler #(
	parameter WIDTH = 7
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_clear,
	input wire [WIDTH-1:0] i_mult,
	output reg o_tick
);
	reg [WIDTH-1:0] cnt_r;
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= {WIDTH{1'b0}};
			o_tick <= 1'b0;
		end else if (i_clear) begin
			cnt_r <= {WIDTH{1'b0}};
			o_tick <= 1'b0;
		end else if (cnt_r >= i_mult - {{(WIDTH-1){1'b0}}, 1'b1}) begin
			cnt_r <= {WIDTH{1'b0}};
			o_tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
			o_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/brgen_top.v ====
// Notes on behaviour
// (R1) after reset the timer is 8 bits wide and uses only the low divisor byte.
// (R2) setting wide_count_select makes the timer a 16-bit counter on both bytes.
// (R3) the timer runs freely, its period set by the divisor pair.
// (R4) in async mode the multiplier depends on high_speed_select and wide_count_select.
// (R5) in sync mode high_speed_select has no effect on the rate.
// (R6) a write to either divisor byte clears the timer count.
// (R7) the new rate starts at once after a divisor write, with no wait for overflow.
// (R8) async, 8-bit, low speed gives a rate of clock over 64 times divisor plus one.
// (R9) one generator times both async and sync operation.
// (R11) async high speed or 16-bit uses multiplier 16, both set uses 4.
`include "brgen_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module brgen_top (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire [3:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [3:0] i_byteenable,
	output reg [31:0] o_readdata,
	output reg o_waitrequest,
	output reg o_baud_tick
);

	// ****************************************
	// state codes and widths
	// ****************************************
	localparam [1:0] BUS_IDLE = 2'b01;
	localparam [1:0] BUS_ACK = 2'b10;
	localparam MULT_W = 7;
	localparam CTRL_W = 3;

	// ****************************************
	// registers and their next values
	// ****************************************
	reg [1:0] bus_state_r;
	reg [1:0] bus_state_nxt;
	reg waitrequest_nxt;
	reg [31:0] readdata_nxt;
	reg [7:0] divisor_low_byte_r;
	reg [7:0] divisor_low_byte_nxt;
	reg [7:0] divisor_high_byte_r;
	reg [7:0] divisor_high_byte_nxt;
	reg [CTRL_W-1:0] ctrl_r;
	reg [CTRL_W-1:0] ctrl_nxt;
	reg [15:0] count_r;
	reg [15:0] count_nxt;
	reg baud_tick_nxt;
	reg [MULT_W-1:0] mult;
	wire pre_tick;

	// ****************************************
	// bus decode
	// ****************************************
	wire bus_idle = bus_state_r[0];
	wire bus_ack = bus_state_r[1];
	wire take = bus_idle & (i_read | i_write);
	// a write lands at the edge where the master sees waitrequest low,
	// so no write is half done when the answer is seen
	wire wr_done = bus_ack & i_write & i_byteenable[0];
	wire sel_low = (i_address == `BRGEN_OFS_DIV_LOW);
	wire sel_high = (i_address == `BRGEN_OFS_DIV_HIGH);
	wire sel_ctrl = (i_address == `BRGEN_OFS_CTRL);
	// clear on the same edge as the byte update, so old and new never mix
	wire div_wr = wr_done & (sel_low | sel_high); // (R6)

	// ****************************************
	// mode decode
	// ****************************************
	// limitation: a control write does not restart the timer, so the
	// first period after a mode change may mix old and new settings
	wire wide = ctrl_r[`BRGEN_CTRL_WIDE];
	wire high_speed = ctrl_r[`BRGEN_CTRL_HIGH_SPEED];
	wire sync_mode = ctrl_r[`BRGEN_CTRL_SYNC];
	wire [15:0] period = wide ? {divisor_high_byte_r, divisor_low_byte_r} : // (R2)
		{8'h00, divisor_low_byte_r}; // (R1)

	// ****************************************
	// bus handshake: one wait cycle, then acknowledge
	// ****************************************
	always @* begin
		bus_state_nxt = bus_state_r;
		waitrequest_nxt = 1'b1;
		case (bus_state_r)
			BUS_IDLE: begin
				if (i_read | i_write) begin
					bus_state_nxt = BUS_ACK;
					waitrequest_nxt = 1'b0;
				end
			end
			BUS_ACK: begin
				// one answer per request, whatever the master does next
				bus_state_nxt = BUS_IDLE;
				waitrequest_nxt = 1'b1;
			end
			default: begin
				bus_state_nxt = BUS_IDLE;
				waitrequest_nxt = 1'b1;
			end
		endcase
	end

	// ****************************************
	// register writes
	// ****************************************
	// status and unmapped words drop writes
	always @* begin
		divisor_low_byte_nxt = divisor_low_byte_r;
		divisor_high_byte_nxt = divisor_high_byte_r;
		ctrl_nxt = ctrl_r;
		if (wr_done) begin
			if (sel_low) begin
				divisor_low_byte_nxt = i_writedata[7:0];
			end
			if (sel_high) begin
				divisor_high_byte_nxt = i_writedata[7:0];
			end
			if (sel_ctrl) begin
				ctrl_nxt = i_writedata[CTRL_W-1:0]; // (R2)
			end
		end
	end

	// ****************************************
	// read data: captured at the take edge, stands while waitrequest is low
	// ****************************************
	always @* begin
		readdata_nxt = o_readdata;
		if (take & i_read) begin
			case (i_address)
				`BRGEN_OFS_DIV_LOW: readdata_nxt = {24'h000000, divisor_low_byte_r};
				`BRGEN_OFS_DIV_HIGH: readdata_nxt = {24'h000000, divisor_high_byte_r};
				`BRGEN_OFS_CTRL: readdata_nxt = {29'h00000000, ctrl_r};
				`BRGEN_OFS_STATUS: readdata_nxt = {24'h000000, mult, wide};
				default: readdata_nxt = 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// multiplier selection
	// ****************************************
	// sync multipliers are this block's own choice
	always @* begin
		if (sync_mode) begin
			mult = wide ? `BRGEN_MULT_1 : `BRGEN_MULT_4; // (R5)
		end else begin
			case ({wide, high_speed}) // (R4)
				2'b00: mult = `BRGEN_MULT_64; // (R8)
				2'b01: mult = `BRGEN_MULT_16; // (R11)
				2'b10: mult = `BRGEN_MULT_16; // (R11)
				default: mult = `BRGEN_MULT_4; // (R11)
			endcase
		end
	end

	// ****************************************
	// period prescaler
	// ****************************************
	// prescaler is shared by async and sync timing
	brgen_prescaler #(.WIDTH(MULT_W)) u_pre ( // (R9)
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clear(div_wr),
		.i_mult(mult),
		.o_tick(pre_tick)
	);

	// ****************************************
	// bus side registers
	// ****************************************
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus_state_r <= BUS_IDLE;
			o_waitrequest <= 1'b1;
			o_readdata <= `BRGEN_RDATA_RESET;
			divisor_low_byte_r <= `BRGEN_DIV_RESET;
			divisor_high_byte_r <= `BRGEN_DIV_RESET;
			ctrl_r <= `BRGEN_CTRL_RESET; // (R1)
		end else begin
			bus_state_r <= bus_state_nxt;
			o_waitrequest <= waitrequest_nxt;
			o_readdata <= readdata_nxt;
			divisor_low_byte_r <= divisor_low_byte_nxt;
			divisor_high_byte_r <= divisor_high_byte_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	// ****************************************
	// free-running divisor timer
	// ****************************************
	// a shrinking period is caught by the compare, not by an exact match
	always @* begin
		count_nxt = count_r;
		baud_tick_nxt = 1'b0;
		if (div_wr) begin
			count_nxt = `BRGEN_COUNT_RESET; // (R6)
			baud_tick_nxt = 1'b0; // (R7)
		end else if (pre_tick) begin
			if (count_r >= period) begin // (R3)
				count_nxt = `BRGEN_COUNT_RESET;
				baud_tick_nxt = 1'b1;
			end else begin
				count_nxt = count_r + 16'h0001;
			end
		end
	end

	// ****************************************
	// timer registers
	// ****************************************
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_r <= `BRGEN_COUNT_RESET;
			o_baud_tick <= 1'b0;
		end else begin
			count_r <= count_nxt;
			o_baud_tick <= baud_tick_nxt;
		end
	end
endmodule
`default_nettype wire

// ==== test/brgen_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module brgen_checker (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire [3:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	input wire [3:0] i_byteenable,
	input wire [31:0] o_readdata,
	input wire o_waitrequest,
	input wire o_baud_tick
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	wire req = i_read | i_write;
	wire rd_ack = i_read && !o_waitrequest;
	// divisor write lands at the acknowledge edge and must silence the tick
	wire div_wr = i_write && !o_waitrequest && i_byteenable[0] &&
		i_address[1:0] == 2'h0 && !i_address[3];
	wait_one_a: assert property (!o_waitrequest |=> o_waitrequest) else $error("long ack");
	ack_cause_a: assert property ($fell(o_waitrequest) |-> $past(req)) else $error("stray ack");
	ack_held_a: assert property (!o_waitrequest |-> req) else $error("ack after release");
	idle_wait_a: assert property (!req |=> o_waitrequest) else $error("idle ack");
	reset_quiet_a: assert property ($rose(i_rst_n) |-> !o_baud_tick [*8])
		else $error("early tick");
	rd_high_a: assert property (rd_ack |-> o_readdata[31:8] == 24'h0) else $error("high bits");
	unmap_zero_a: assert property (rd_ack && |i_address[1:0] |-> o_readdata == 32'h0)
		else $error("unmapped read");
	div_clear_a: assert property (div_wr |=> !o_baud_tick) else $error("tick kept");
	cover property (o_baud_tick);
	cover property (div_wr);
	cover property (rd_ack);
endmodule
bind brgen_top brgen_checker chk_u (
	.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n),
	.i_address(i_address),
	.i_read(i_read),
	.i_write(i_write),
	.i_writedata(i_writedata),
	.i_byteenable(i_byteenable),
	.o_readdata(o_readdata),
	.o_waitrequest(o_waitrequest),
	.o_baud_tick(o_baud_tick)
);
`default_nettype wire

// ==== test/tb_baud_rate_generator.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_baud_rate_generator;
	reg i_ref_clk = 0, i_rst_n = 0, i_read = 0, i_write = 0;
	reg [3:0] i_address = 4'h0, i_byteenable = 4'hf;
	reg [31:0] i_writedata = 32'h0, rd;
	wire [31:0] o_readdata;
	wire o_waitrequest, o_baud_tick;
	integer fails = 0, comparisons = 0, n = 0, e, m;
	brgen_top dut_u (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_address(i_address),
		.i_read(i_read),
		.i_write(i_write),
		.i_writedata(i_writedata),
		.i_byteenable(i_byteenable),
		.o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest),
		.o_baud_tick(o_baud_tick)
	);
	// the clock never changes rate during a run
	initial forever #25 i_ref_clk = ~i_ref_clk;
	task print_verdict;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task cmp(input [23:0] nm, input [31:0] x, input [31:0] g);
		comparisons++;
		fails += (g !== x);
		if (g !== x) $display("Error %s exp %0d got %0d", nm, x, g);
	endtask
	task step;
		@(posedge i_ref_clk);
		n++;
		if (n > 9000) cmp("tmo", 0, n);
		if (n > 9000) print_verdict;
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		i_address <= a;
		i_writedata <= d;
		{i_write, i_read} <= {w, !w};
		while (o_waitrequest) step;
		rd = o_readdata;
		{i_write, i_read} <= 2'h0;
		step;
	endtask
	// first two ticks after a mode change are skipped, they may mix old and new
	task rate(input [2:0] c);
		m = c[2] ? (c[0] ? 1 : 4) : 64 >> 2 * (c[0] + c[1]);
		e = m * (c[0] ? 259 : 3);
		bus(1, 4'h8, {29'h0, c});
		bus(0, 4'h8, 32'h0);
		cmp("ctl", c, rd);
		bus(0, 4'hc, 32'h0);
		cmp("sts", m * 2 + c[0], rd);
		repeat (3) begin
			n = 0;
			step;
			while (!o_baud_tick) step;
		end
		cmp("per", e, n);
	endtask
	// reset state, read-back, and a write with lane 0 off that must not land
	task regs;
		bus(0, 4'hc, 32'h0);
		cmp("sts", 64 * 2, rd);
		bus(1, 4'h0, 32'h2);
		bus(1, 4'h4, 32'h1);
		i_byteenable <= 4'he;
		bus(1, 4'h0, 32'h55);
		i_byteenable <= 4'hf;
		bus(0, 4'h0, 32'h0);
		cmp("dlo", 2, rd);
		bus(0, 4'h4, 32'h0);
		cmp("dhi", 1, rd);
		bus(0, 4'h1, 32'h0);
		cmp("map", 0, rd);
	endtask
	// a divisor write mid-period restarts the timer at once, at the new rate
	task restart;
		bus(1, 4'h8, 32'h0);
		n = 0;
		step;
		while (!o_baud_tick) step;
		repeat (50) step;
		bus(1, 4'h0, 32'h5);
		n = 1;
		while (!o_baud_tick) step;
		cmp("rst", 64 * 6 + 2, n);
		n = 0;
		step;
		while (!o_baud_tick) step;
		cmp("per", 64 * 6, n);
	endtask
	initial begin
		repeat (2) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		regs;
		for (int i = 0; i < 8; i++) rate(i[2:0]);
		restart;
		print_verdict;
	end
endmodule
`default_nettype wire
